//--- tb/dds_host_model.sv
// Purpose: host side pin model for the programming port
// Assumes: pins change just after an mclk edge
// Notes:   serial clock is 8 mclk and idles low between frames
`timescale 1ns/1ps
module dds_host_model (
  input  wire logic       mclk,
  output logic            sel,
  output logic            wr,
  output logic            cs,
  output wire logic [5:0] addr,
  output wire logic [7:0] din,
  output wire logic       upd,
  input  wire logic       sdo,
  input  wire logic       sdo_oe,
  input  wire logic       sdio,
  input  wire logic       sdio_oe,
  input  wire logic [7:0] dout,
  input  wire logic       doe,
  input  wire logic       uo,
  input  wire logic       uoe
);
  logic [5:0] ha;
  logic [7:0] hd;
  logic       hu;
  logic       rel;
  logic       tog = 1'b0;
  // ----------------------------------------------------------------
  // shared wires
  // ----------------------------------------------------------------
  // released line toggles so a stale value cannot pass
  assign addr = {ha[5:2], sdo_oe ? sdo : ha[1],
                 sdio_oe ? sdio : (rel ? tog : ha[0])};
  assign din  = doe ? dout : hd;
  assign upd  = uoe ? uo : hu;
  always @(posedge mclk) tog <= ~tog;
  initial begin
    {wr, ha, hd, hu, rel} = '0;
    sel = 1'b1;
    cs = 1'b1;
  end
  // ----------------------------------------------------------------
  // transfers
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic mode(input logic s);
    sel <= s;
    tick(6);
  endtask
  task automatic frame(input logic v);
    cs <= v;
    tick(4);
  endtask
  task automatic par_wr(input logic [5:0] a, input logic [7:0] d);
    ha <= a;
    hd <= d;
    tick(4);
    wr <= 1'b1;
    tick(4);
    wr <= 1'b0;
    tick(4);
  endtask
  task automatic par_rd(input logic [5:0] a, output logic [7:0] d);
    ha <= a;
    cs <= 1'b0;
    tick(6);
    d = din;
    cs <= 1'b1;
    tick(6);
  endtask
  task automatic ser(input logic [15:0] w, input int n, input logic t3,
                     output logic [7:0] q);
    for (int i = 0; i < n; i++) begin
      rel <= w[15] && i >= 8;
      ha[0] <= w[15-i];
      wr <= 1'b0;
      tick(4);
      q = {q[6:0], t3 ? addr[1] : addr[0]};
      wr <= 1'b1;
      tick(4);
    end
    wr <= 1'b0;
    rel <= 1'b0;
    tick(4);
  endtask
  task automatic io_reset;
    ha[2] <= 1'b1;
    tick(6);
    ha[2] <= 1'b0;
    tick(6);
  endtask
  task automatic upd_edge;
    hu <= 1'b1;
    tick(6);
    hu <= 1'b0;
    tick(6);
  endtask
endmodule // dds_host_model

//--- tb/dds_programming_port_tb_top.sv
// Purpose: self-checking bench for the programming port
// Assumes: design latencies as handed over, 2-3 mclk sync lag
// Notes:   expectations come from written values and fixed constants
`timescale 1ns/1ps
module dds_programming_port_tb_top
  import dds_port_pkg::*;
();
  logic                      mclk = 1'b0;
  logic                      arst_n = 1'b0;
  logic                      fu = 1'b0;
  int                        miscompares = 0;
  int                        checked = 0;
  logic [7:0]                q;
  wire logic                 sel, wr, cs, upd, sdo, sdo_oe, sdio, sdio_oe;
  wire logic                 doe, uo, uoe;
  wire logic [5:0]           addr;
  wire logic [7:0]           din, dout;
  wire logic [REG_NUM*DATA_W-1:0] act;
  dds_programming_port uut (.mclk(mclk), .arst_n(arst_n),
    .ser_par_select(sel), .wr_sclk(wr), .rd_cs_n(cs),
    .parallel_register_address(addr), .sdo_out(sdo), .sdo_oe(sdo_oe),
    .sdio_out(sdio), .sdio_oe(sdio_oe), .parallel_data_bus_in(din),
    .parallel_data_bus_out(dout), .parallel_data_bus_oe(doe),
    .buffer_transfer_strobe_in(upd), .buffer_transfer_strobe_out(uo),
    .buffer_transfer_strobe_oe(uoe), .freq_update(fu), .active_regs(act));
  dds_host_model host (.mclk(mclk), .sel(sel), .wr(wr), .cs(cs),
    .addr(addr), .din(din), .upd(upd), .sdo(sdo), .sdo_oe(sdo_oe),
    .sdio(sdio), .sdio_oe(sdio_oe), .dout(dout), .doe(doe), .uo(uo),
    .uoe(uoe));
  initial forever #5 mclk = ~mclk;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  function automatic logic [7:0] rg(input int a);
    return act[8*a +: 8];
  endfunction
  task automatic pulse_upd;
    int n;
    n = 0;
    @(posedge mclk) fu <= 1'b1;
    @(posedge mclk) fu <= 1'b0;
    repeat (16) @(negedge mclk) n += int'(uo === 1'b1);
    chk(8'(n), 8'h08);
    @(posedge mclk);
  endtask
  task automatic wrap_up;
    if (miscompares == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_par;
    @(negedge mclk) chk(uoe, 1'b1);
    chk(doe, 1'b0);
    @(posedge mclk);
    host.par_wr(6'h05, 8'ha5);
    host.par_wr(6'h2a, 8'h4d);
    chk(rg(5), REG_RESET);
    pulse_upd();
    chk(rg(5), 8'ha5);
    chk(rg(42), 8'h4d);
    host.par_rd(6'h05, q);
    chk(q, 8'ha5);
    host.par_rd(6'h2a, q);
    chk(q, 8'h4d);
    @(negedge mclk) chk(doe, 1'b0);
    @(posedge mclk);
  endtask
  task automatic t_ser;
    host.mode(1'b0);
    host.frame(1'b0);
    chk(doe, 1'b0);
    host.ser(16'h063c, 16, 1'b0, q);
    host.frame(1'b1);
    pulse_upd();
    chk(rg(6), 8'h3c);
    host.frame(1'b0);
    host.ser(16'h8500, 16, 1'b0, q);
    host.frame(1'b1);
    chk(q, 8'ha5);
  endtask
  task automatic t_iorst;
    host.frame(1'b0);
    host.ser(16'hffff, 3, 1'b0, q);
    host.io_reset();
    chk(rg(6), 8'h3c);
    host.ser(16'h075a, 16, 1'b0, q);
    host.frame(1'b1);
    pulse_upd();
    chk(rg(7), 8'h5a);
    chk(rg(6), 8'h3c);
  endtask
  task automatic t_dir;
    host.mode(1'b1);
    host.par_wr(CTRL_ADDR, 8'h03);
    host.par_wr(6'h08, 8'h99);
    @(negedge mclk) chk(uoe, 1'b0);
    @(posedge mclk) fu <= 1'b1;
    @(posedge mclk) fu <= 1'b0;
    repeat (4) @(posedge mclk);
    chk(rg(8), REG_RESET);
    chk(uo, 1'b0);
    host.upd_edge();
    chk(rg(8), 8'h99);
    host.mode(1'b0);
    host.frame(1'b0);
    host.ser(16'h8700, 16, 1'b1, q);
    host.frame(1'b1);
    chk(q, 8'h5a);
  endtask
  task automatic t_rst;
    @(posedge mclk) arst_n <= 1'b0;
    @(negedge mclk) chk(uoe, 1'b1);
    chk(rg(8), REG_RESET);
    chk(doe, 1'b0);
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    pulse_upd();
    chk(rg(7), REG_RESET);
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    t_par();
    t_ser();
    t_iorst();
    t_dir();
    t_rst();
    wrap_up();
  end
  // hang guard: well beyond the under one thousand cycles needed
  initial begin
    #500000;
    miscompares++;
    wrap_up();
  end
endmodule // dds_programming_port_tb_top

//--- verilog/dds_port_pkg.sv
// Purpose: shared constants and carriers for the programming port
// Assumes: 8-bit registers, 6-bit register address
// Notes:   control byte lives in the buffer bank at CTRL_ADDR
package dds_port_pkg;
  // ----------------------------------------------------------------
  // sizes and map
  // ----------------------------------------------------------------
  localparam int          DATA_W        = 8;
  localparam int          ADDR_W        = 6;
  localparam int          REG_NUM       = 64;
  localparam logic [5:0]  CTRL_ADDR     = 6'h1f;
  localparam int          CTRL_DIR_BIT  = 0;
  localparam int          CTRL_3W_BIT   = 1;
  localparam logic [7:0]  REG_RESET     = 8'h00;
  localparam int          INSTR_RD_BIT  = 7;
  localparam int          IO_RST_BIT    = 2;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam logic [3:0]  UPD_PULSE_CYC = 4'h8;
  localparam logic [2:0]  LAST_BIT      = 3'h7;

  typedef enum logic [1:0] {
    S_INSTR = 2'b00,
    S_WDATA = 2'b01,
    S_RDATA = 2'b11
  } ser_state_t;

  // one sample of every pin that arrives from the host
  typedef struct packed {
    logic       par_sel;
    logic       wr_sclk;
    logic       rd_cs_n;
    logic [5:0] addr;
    logic [7:0] data;
    logic       upd;
  } pin_in_t;
endpackage

//--- verilog/dds_programming_port.sv
// Purpose: pin-level programming port, parallel and serial
// Assumes: host pins are asynchronous to mclk and held long enough
//          to be seen through a two-stage synchroniser
// Notes:   buffers move to active registers on an update
// How it works
// - the 8-bit data bus is driven only in parallel mode.
// - address bit two high in serial mode resets the serial engine.
// - that serial reset leaves every register value untouched.
// - in 3-wire serial mode address bit one drives read data out.
// - in 2-wire serial mode address bit zero carries data both ways.
// - a control bit picks the update pin direction, output by default.
// - as input, a rising update edge copies buffers to active registers.
// - as output, each internal update gives an 8-cycle high pulse.
// - serial data is taken on the rising serial clock edge.
// - a parallel write strobe stores the bus byte in the buffer.
// - a parallel read strobe drives the active register on the bus.
// - the select input decides strobe or serial roles of shared pins.
`timescale 1ns/1ps
module dds_programming_port
  import dds_port_pkg::*;
(
  input  wire logic                      mclk,
  input  wire logic                      arst_n,
  input  wire logic                      ser_par_select,
  input  wire logic                      wr_sclk,
  input  wire logic                      rd_cs_n,
  input  wire logic [ADDR_W-1:0]         parallel_register_address,
  output logic                           sdo_out,
  output logic                           sdo_oe,
  output logic                           sdio_out,
  output logic                           sdio_oe,
  input  wire logic [DATA_W-1:0]         parallel_data_bus_in,
  output logic      [DATA_W-1:0]         parallel_data_bus_out,
  output logic                           parallel_data_bus_oe,
  input  wire logic                      buffer_transfer_strobe_in,
  output logic                           buffer_transfer_strobe_out,
  output logic                           buffer_transfer_strobe_oe,
  input  wire logic                      freq_update,
  output logic [REG_NUM*DATA_W-1:0]      active_regs
);
  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  pin_in_t s1_q, s2_q, s3_q;
  pin_in_t raw;

  assign raw = '{par_sel: ser_par_select, wr_sclk: wr_sclk,
                 rd_cs_n: rd_cs_n, addr: parallel_register_address,
                 data: parallel_data_bus_in,
                 upd: buffer_transfer_strobe_in};

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      // idle levels, so no read or frame is seen straight after reset
      s1_q <= '{rd_cs_n: 1'b1, default: '0};
      s2_q <= '{rd_cs_n: 1'b1, default: '0};
      s3_q <= '{rd_cs_n: 1'b1, default: '0};
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // edge of a synchronised pin, one stage behind the second flop
  function automatic logic rising(input logic now_v, input logic was_v);
    return now_v && !was_v;
  endfunction

  logic par_mode, ser_mode, sclk_rise, wr_rise, upd_rise;
  logic cs_act, io_rst, sdi;
  assign par_mode  = s2_q.par_sel;
  assign ser_mode  = !s2_q.par_sel;
  assign wr_rise   = par_mode && rising(s2_q.wr_sclk, s3_q.wr_sclk);
  assign sclk_rise = ser_mode && rising(s2_q.wr_sclk, s3_q.wr_sclk);
  assign cs_act    = ser_mode && !s2_q.rd_cs_n;
  assign io_rst    = ser_mode && s2_q.addr[IO_RST_BIT];
  assign upd_rise  = rising(s2_q.upd, s3_q.upd);
  assign sdi       = s2_q.addr[0];

  // ----------------------------------------------------------------
  // register banks
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] buf_q [REG_NUM];
  logic [DATA_W-1:0] act_q [REG_NUM];
  logic              dir_in, three_wire, xfer;
  logic              ser_wr;
  logic [ADDR_W-1:0] ser_addr_q;
  logic [DATA_W-1:0] ser_byte;

  assign dir_in     = buf_q[CTRL_ADDR][CTRL_DIR_BIT];
  assign three_wire = buf_q[CTRL_ADDR][CTRL_3W_BIT];
  assign xfer       = dir_in ? upd_rise : freq_update;

  // a write and a transfer in one cycle copy the older buffer value
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < REG_NUM; i++) begin
        buf_q[i] <= REG_RESET;
      end
    end else if (wr_rise) begin
      buf_q[s2_q.addr] <= s2_q.data;
    end else if (ser_wr) begin
      buf_q[ser_addr_q] <= ser_byte;
    end
  end

  // no serial reset term here: only power-on reset restores defaults
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < REG_NUM; i++) begin
        act_q[i] <= REG_RESET;
      end
    end else if (xfer) begin
      for (int i = 0; i < REG_NUM; i++) begin
        act_q[i] <= buf_q[i];
      end
    end
  end

  for (genvar g = 0; g < REG_NUM; g++) begin : g_act
    assign active_regs[g*DATA_W +: DATA_W] = act_q[g];
  end

  // ----------------------------------------------------------------
  // parallel read
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      parallel_data_bus_oe  <= 1'b0;
      parallel_data_bus_out <= '0;
    end else begin
      parallel_data_bus_oe  <= par_mode && !s2_q.rd_cs_n;
      parallel_data_bus_out <= act_q[s2_q.addr];
    end
  end

  // ----------------------------------------------------------------
  // serial engine
  // ----------------------------------------------------------------
  // a partial byte is dropped when the frame closes
  ser_state_t        st_q;
  logic [2:0]        bit_q;
  logic [DATA_W-1:0] sh_q, tx_q;
  logic              byte_done;

  assign ser_byte  = {sh_q[DATA_W-2:0], sdi};
  assign byte_done = sclk_rise && cs_act && bit_q == LAST_BIT;
  assign ser_wr    = byte_done && st_q == S_WDATA && !io_rst;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q       <= S_INSTR;
      bit_q      <= '0;
      sh_q       <= '0;
      ser_addr_q <= '0;
    end else if (io_rst || !cs_act) begin
      st_q  <= S_INSTR;
      bit_q <= '0;
    end else if (sclk_rise) begin
      sh_q  <= ser_byte;
      bit_q <= bit_q + 3'h1;
      if (bit_q == LAST_BIT) begin
        case (st_q)
          S_INSTR: begin
            ser_addr_q <= ser_byte[ADDR_W-1:0];
            st_q <= ser_byte[INSTR_RD_BIT] ? S_RDATA : S_WDATA;
          end
          S_WDATA: st_q <= S_INSTR;
          S_RDATA: st_q <= S_INSTR;
          default: st_q <= S_INSTR;
        endcase
      end
    end
  end

  // read byte leaves msb first; each rising edge moves to the next bit
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tx_q <= '0;
    end else if (byte_done && st_q == S_INSTR) begin
      tx_q <= act_q[ser_byte[ADDR_W-1:0]];
    end else if (sclk_rise && cs_act && st_q == S_RDATA) begin
      tx_q <= {tx_q[DATA_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sdo_out  <= 1'b0;
      sdo_oe   <= 1'b0;
      sdio_out <= 1'b0;
      sdio_oe  <= 1'b0;
    end else begin
      sdo_out  <= tx_q[DATA_W-1];
      sdo_oe   <= cs_act && three_wire;
      sdio_out <= tx_q[DATA_W-1];
      sdio_oe  <= cs_act && !three_wire && st_q == S_RDATA;
    end
  end

  // ----------------------------------------------------------------
  // update pin
  // ----------------------------------------------------------------
  // reload on every update, so a retrigger stretches the pulse
  logic [3:0] upd_cnt_q, upd_cnt_d;

  always_comb begin
    upd_cnt_d = upd_cnt_q;
    if (!dir_in && freq_update) begin
      upd_cnt_d = UPD_PULSE_CYC;
    end else if (upd_cnt_q != 4'h0) begin
      upd_cnt_d = upd_cnt_q - 4'h1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      upd_cnt_q                  <= '0;
      buffer_transfer_strobe_out <= 1'b0;
      buffer_transfer_strobe_oe  <= 1'b1;
    end else begin
      upd_cnt_q                  <= upd_cnt_d;
      buffer_transfer_strobe_out <= upd_cnt_d != 4'h0;
      buffer_transfer_strobe_oe  <= !dir_in;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // properties watch internal state, so they live beside it
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  upd_pulse_len_a: assert property (
    !dir_in && freq_update |=> buffer_transfer_strobe_out [*8])
    else $error("update pulse shorter than eight cycles");
  // a retrigger restarts the pulse, so only a quiet pulse must end
  upd_pulse_end_a: assert property (
    ($rose(buffer_transfer_strobe_out) && !freq_update) ##1
    (!freq_update [*7]) |=> !buffer_transfer_strobe_out)
    else $error("update pulse longer than eight cycles");
  upd_dir_a: assert property (
    ##1 buffer_transfer_strobe_oe == !$past(dir_in))
    else $error("update pin direction wrong");
  upd_copy_a: assert property (
    dir_in && upd_rise |=> act_q[0] == $past(buf_q[0]))
    else $error("update edge did not copy buffers");
  upd_quiet_a: assert property (
    dir_in && upd_cnt_q == 4'h0 |=> !buffer_transfer_strobe_out)
    else $error("update pulse while the pin is an input");
  // freq_update has no effect while the pin is an input
  upd_in_ign_a: assert property (
    dir_in && !upd_rise |=> act_q[0] == $past(act_q[0]))
    else $error("active registers moved without an update edge");

  // ----------------------------------------------------------------
  // port and serial checks
  // ----------------------------------------------------------------
  par_write_a: assert property (
    wr_rise |=> buf_q[$past(s2_q.addr)] == $past(s2_q.data))
    else $error("parallel write lost");
  par_read_a: assert property (
    par_mode && !s2_q.rd_cs_n |=> parallel_data_bus_oe &&
    parallel_data_bus_out == $past(act_q[s2_q.addr]))
    else $error("parallel read data wrong");
  bus_idle_a: assert property (
    ser_mode |=> !parallel_data_bus_oe)
    else $error("data bus driven in serial mode");
  io_rst_fsm_a: assert property (
    io_rst |=> st_q == S_INSTR && bit_q == 3'h0)
    else $error("serial reset ignored");
  io_rst_keep_a: assert property (
    io_rst && !xfer |=> act_q[CTRL_ADDR] == $past(act_q[CTRL_ADDR]))
    else $error("serial reset touched registers");
  sdo_drive_a: assert property (
    sdo_oe |-> $past(cs_act) && $past(three_wire))
    else $error("sdo driven outside 3-wire mode");
  sdio_dir_a: assert property (
    sdio_oe |-> !sdo_oe && $past(st_q) == S_RDATA)
    else $error("sdio driven out of turn");
  ser_write_a: assert property (
    ser_wr |=> buf_q[$past(ser_addr_q)] == $past(ser_byte))
    else $error("serial write lost");
  cs_frame_a: assert property (
    !cs_act |=> st_q == S_INSTR && bit_q == 3'h0)
    else $error("serial engine ran outside a frame");
  io_rst_buf_a: assert property (
    io_rst |=> buf_q[CTRL_ADDR] == $past(buf_q[CTRL_ADDR]))
    else $error("serial reset touched buffers");
  sdo_shift_a: assert property (
    sclk_rise && cs_act && st_q == S_RDATA |=>
    tx_q == {$past(tx_q[DATA_W-2:0]), 1'b0})
    else $error("read data did not shift");

  cov_par_wr_c:  cover property (wr_rise ##[1:200] xfer);
  cov_ser_rd_c:  cover property (byte_done && st_q == S_RDATA);
  cov_upd_out_c: cover property ($fell(buffer_transfer_strobe_out));
  cov_io_rst_c:  cover property (io_rst ##1 !io_rst ##[1:400] ser_wr);
  cov_upd_in_c:  cover property (dir_in && upd_rise);
endmodule // dds_programming_port
